// [bmx_map.svh]
// bmx_map.svh: command codes and timing counts for the bus exception controller
// assumes a 200 MHz system clock (5 ns period)
`ifndef BMX_MAP_SVH
`define BMX_MAP_SVH

// ----------------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------------
`define BMX_CMD_RESET        8'hff

// ----------------------------------------------------------------------------
// timing counts in clock cycles
// ----------------------------------------------------------------------------
`define BMX_RST_HOLD_CYC     4'ha
`define BMX_CMD_LOCK_CYC     3'h4

`endif

// [bmx_pkg.sv]
// bmx_pkg.sv: types for the bus exception controller
// assumes bmx_map.svh is compiled alongside
package bmx_pkg;

  // --------------------------------------------------------------------------
  // exception inputs as sampled, active high inside the block
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic halt;
    logic bus_error_in;
    logic retry;
  } bmx_exc_t;

  // --------------------------------------------------------------------------
  // master sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    BMX_IDLE,
    BMX_REQ,
    BMX_OWN,
    BMX_HALTED,
    BMX_BUS_ERROR_IN_WAIT,
    BMX_RETRY_WAIT
  } bmx_state_t;

endpackage

// [bmx_ctrl.sv]
// bmx_ctrl.sv: bus request, grant and exception handling for the DMA master
// assumes all inputs synchronous to ref_clk; cycle sequencer lives outside
// Operation
// - hardware reset pin honoured in every state
// - halt, bus error, retry ignored unless requesting or owning bus
// - active exception ends current cycle, then wait for its release
// - exception acted on at once, before, with, or after ready
// - halt lets current cycle finish with ready, then bus activity stops
// - while halted, give up bus and stay idle until halt released
// - after halt, request bus again and resume pending transfers
// - bus error abandons cycle and releases ownership
// - after bus error clears, rearbitrate to report error to host
// - retry ends cycle, waits, keeps request asserted to hold bus
// - after retry clears, rerun the cycle at the same address
// - command code ff acts exactly like hardware reset
// - no command accepted for four clocks after any reset
// - request bus when DMA needed, start cycles only after grant
// - grant withdrawn early is handled like halt
`timescale 1ns/10ps
`include "bmx_map.svh"

module bmx_ctrl (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // external bus pins, active low where noted
  input  wire logic        reset_n_in,
  input  wire logic        halt_n_in,
  input  wire logic        bus_error_n_in,
  input  wire logic        retry_n_in,
  input  wire logic        bus_grant_in,
  output logic             bus_request_out,
  // host command port
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  output logic             cmd_ready,
  // dma side
  input  wire logic        dma_pending,
  input  wire logic [31:0] dma_addr,
  // cycle sequencer side
  input  wire logic        cyc_ready,
  input  wire logic        cyc_last,
  output logic             cyc_start,
  output logic             cyc_abort,
  output logic [31:0]      cyc_addr,
  // status toward the host
  output logic             bus_error_in_pending,
  input  wire logic        bus_error_in_reported,
  output logic             soft_reset
);

  // --------------------------------------------------------------------------
  // registered inputs
  // --------------------------------------------------------------------------
  bmx_pkg::bmx_exc_t   exc_q;
  logic                grant_q;
  logic                hw_rst_q;
  bmx_pkg::bmx_state_t state_q, state_d;
  logic                in_cyc_q;
  logic [2:0]          lock_q;

  // sample pins once so every decision uses one consistent snapshot
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exc_q    <= '0;
      grant_q  <= 1'b0;
      hw_rst_q <= 1'b0;
    end else if (clk_en) begin
      exc_q    <= '{halt: ~halt_n_in, bus_error_in: ~bus_error_n_in, retry: ~retry_n_in};
      grant_q  <= bus_grant_in;
      hw_rst_q <= ~reset_n_in;
    end
  end

  // --------------------------------------------------------------------------
  // reset decode
  // --------------------------------------------------------------------------
  wire lock_open = (lock_q == 3'h0);
  wire soft_rst  = cmd_valid && cmd_ready && (cmd_code == `BMX_CMD_RESET);
  logic soft_q;
  wire any_rst   = hw_rst_q || soft_q;

  // hold-off after reset; the pulse length of the pin is the agent's duty
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      soft_q <= 1'b0;
      lock_q <= `BMX_CMD_LOCK_CYC;
    end else if (clk_en) begin
      soft_q <= soft_rst;
      if (any_rst)
        lock_q <= `BMX_CMD_LOCK_CYC;
      else if (!lock_open)
        lock_q <= lock_q - 3'h1;
    end
  end

  // --------------------------------------------------------------------------
  // exception decode
  // --------------------------------------------------------------------------
  wire mastering  = (state_q == bmx_pkg::BMX_REQ) || (state_q == bmx_pkg::BMX_OWN);
  wire exc_halt   = mastering && (exc_q.halt || (state_q == bmx_pkg::BMX_OWN && !grant_q));
  wire exc_bus_error_in   = mastering && exc_q.bus_error_in;
  wire exc_retry  = mastering && exc_q.retry;
  wire exc_any    = exc_halt || exc_bus_error_in || exc_retry;
  // halt and grant loss let the cycle run to its ready; only these and any reset abandon it
  wire exc_stop   = exc_bus_error_in || exc_retry;
  wire want_bus   = dma_pending || bus_error_in_pending;

  // --------------------------------------------------------------------------
  // master sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      bmx_pkg::BMX_IDLE:
        if (want_bus && lock_open)
          state_d = bmx_pkg::BMX_REQ;
      bmx_pkg::BMX_REQ:
        if (exc_bus_error_in)
          state_d = bmx_pkg::BMX_BUS_ERROR_IN_WAIT;
        else if (exc_halt)
          state_d = bmx_pkg::BMX_HALTED;
        else if (exc_retry)
          state_d = bmx_pkg::BMX_RETRY_WAIT;
        else if (grant_q)
          state_d = bmx_pkg::BMX_OWN;
      bmx_pkg::BMX_OWN:
        if (exc_bus_error_in)
          state_d = bmx_pkg::BMX_BUS_ERROR_IN_WAIT;
        else if (exc_halt)
          state_d = bmx_pkg::BMX_HALTED;
        else if (exc_retry)
          state_d = bmx_pkg::BMX_RETRY_WAIT;
        else if (!in_cyc_q && !want_bus)
          state_d = bmx_pkg::BMX_IDLE;
      bmx_pkg::BMX_HALTED:
        if (!exc_q.halt)
          state_d = bmx_pkg::BMX_IDLE;
      bmx_pkg::BMX_BUS_ERROR_IN_WAIT:
        if (!exc_q.bus_error_in)
          state_d = bmx_pkg::BMX_IDLE;
      bmx_pkg::BMX_RETRY_WAIT:
        if (!exc_q.retry)
          state_d = bmx_pkg::BMX_OWN;
      default:
        state_d = bmx_pkg::BMX_IDLE;
    endcase
  end

  // outputs; any reset forces the sequencer home in every state
  wire start_ok = (state_d == bmx_pkg::BMX_OWN) && !in_cyc_q && dma_pending && !cyc_start && !exc_any;
  wire cyc_done = in_cyc_q && (cyc_ready || exc_stop);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q         <= bmx_pkg::BMX_IDLE;
      in_cyc_q        <= 1'b0;
      bus_request_out <= 1'b0;
      cyc_start       <= 1'b0;
      cyc_abort       <= 1'b0;
      cyc_addr        <= 32'h0000_0000;
      bus_error_in_pending    <= 1'b0;
      cmd_ready       <= 1'b0;
      soft_reset      <= 1'b0;
    end else if (clk_en) begin
      if (any_rst) begin
        state_q         <= bmx_pkg::BMX_IDLE;
        in_cyc_q        <= 1'b0;
        bus_request_out <= 1'b0;
        cyc_start       <= 1'b0;
        cyc_abort       <= in_cyc_q;
        bus_error_in_pending    <= 1'b0;
        cmd_ready       <= 1'b0;
      end else begin
        state_q         <= state_d;
        bus_request_out <= (state_d == bmx_pkg::BMX_REQ) || (state_d == bmx_pkg::BMX_OWN)
                           || (state_d == bmx_pkg::BMX_RETRY_WAIT);
        cyc_start       <= start_ok;
        cyc_abort       <= in_cyc_q && exc_stop && !cyc_ready;
        if (start_ok && state_q != bmx_pkg::BMX_RETRY_WAIT)
          cyc_addr <= dma_addr; // retry keeps the held address
        if (start_ok)
          in_cyc_q <= 1'b1;
        else if (cyc_done || (cyc_last && cyc_ready))
          in_cyc_q <= 1'b0;
        // set wins over the host's acknowledge
        if (exc_bus_error_in)
          bus_error_in_pending <= 1'b1;
        else if (bus_error_in_reported)
          bus_error_in_pending <= 1'b0;
        cmd_ready       <= lock_open && !soft_rst;
      end
      soft_reset <= soft_rst;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  rst_forces_idle_a: assert property (clk_en && any_rst |=> state_q == bmx_pkg::BMX_IDLE)
    else $error("reset did not return sequencer to idle");
  exc_ignored_idle_a: assert property (clk_en && state_q == bmx_pkg::BMX_IDLE && !any_rst |=>
    state_q inside {bmx_pkg::BMX_IDLE, bmx_pkg::BMX_REQ})
    else $error("exception acted on while idle");
  exc_ends_cycle_a: assert property (clk_en && in_cyc_q && exc_stop && !cyc_ready && !any_rst |=> cyc_abort)
    else $error("exception did not abort the cycle");
  halt_waits_ready_a: assert property (clk_en && in_cyc_q && exc_halt && !exc_stop && !any_rst |=> !cyc_abort)
    else $error("halt abandoned the cycle instead of waiting for ready");
  exc_immediate_a: assert property (clk_en && exc_any && !any_rst |=> !cyc_start)
    else $error("new cycle started during exception");
  halt_drops_req_a: assert property (clk_en && state_q == bmx_pkg::BMX_HALTED && exc_q.halt
    && !any_rst |=> !bus_request_out)
    else $error("request held while halted");
  bus_error_in_release_a: assert property (clk_en && state_q == bmx_pkg::BMX_OWN && exc_bus_error_in && !any_rst
    |=> !bus_request_out && bus_error_in_pending)
    else $error("bus error did not release bus");
  retry_keeps_req_a: assert property (clk_en && state_q == bmx_pkg::BMX_RETRY_WAIT && !any_rst
    |=> bus_request_out)
    else $error("retry dropped bus request");
  retry_same_addr_a: assert property (clk_en && state_q == bmx_pkg::BMX_RETRY_WAIT |=> $stable(cyc_addr))
    else $error("retry changed address");
  lock_after_rst_a: assert property (clk_en && any_rst |=> !cmd_ready)
    else $error("command accepted right after reset");
  start_needs_grant_a: assert property (cyc_start |-> state_q == bmx_pkg::BMX_OWN)
    else $error("cycle started without grant");

  halt_seen_c: cover property (state_q == bmx_pkg::BMX_OWN ##1 state_q == bmx_pkg::BMX_HALTED);
  bus_error_in_seen_c: cover property (state_q == bmx_pkg::BMX_BUS_ERROR_IN_WAIT ##[1:20] state_q == bmx_pkg::BMX_REQ);
  retry_seen_c: cover property (state_q == bmx_pkg::BMX_RETRY_WAIT ##1 state_q == bmx_pkg::BMX_OWN);
  soft_rst_c: cover property (soft_reset);

endmodule // bmx_ctrl

// [bmx_bus_model.sv]
// bmx_bus_model.sv: arbiter and memory responder facing the bus controller
// assumes one ref_clk shared with the controller; the bench picks ready latency
`timescale 1ns/10ps

module bmx_bus_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // bench controls
  input  wire logic       grant_kill,
  input  wire logic [2:0] lat,
  // controller side
  input  wire logic       bus_request_out,
  input  wire logic       cyc_start,
  input  wire logic       cyc_abort,
  output logic            bus_grant_in,
  output logic            cyc_ready
);
  logic [2:0] cnt_q;

  // grant trails request by a cycle; ready comes lat+1 cycles after a start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_grant_in <= 1'b0;
      cnt_q        <= 3'h0;
      cyc_ready    <= 1'b0;
    end else begin
      bus_grant_in <= bus_request_out & ~grant_kill;
      cnt_q        <= cyc_start ? lat : (cyc_abort || cnt_q == 3'h0) ? 3'h0 : cnt_q - 3'h1;
      cyc_ready    <= (cnt_q == 3'h1);
    end
  end
endmodule // bmx_bus_model

// [bus_master_exception_control_tb.sv]
// bus_master_exception_control_tb.sv: self-checking bench for bmx_ctrl
// assumes bmx_bus_model answers the bus; inputs change 1 ns after the edge
`timescale 1ns/10ps

module bus_master_exception_control_tb;
  typedef struct packed {logic [3:0] exc; logic [2:0] lat; logic keep; logic bus_error_in;} bmx_row_t;
  logic ref_clk = 0, rst = 1, reset_n_in = 1, cmd_valid = 0, dma_pending = 0, bus_error_in_reported = 0;
  logic clk_en = 1;
  logic [7:0] cmd_code = 8'h00;
  logic [31:0] dma_addr = 32'h0, a;
  logic [3:0] exc = 4'h0; // kill, halt, bus_error_in, retry
  logic [2:0] lat = 3'h4;
  logic bus_grant_in, bus_request_out, cmd_ready, cyc_ready, cyc_start, cyc_abort, bus_error_in_pending, soft_reset;
  logic [31:0] cyc_addr;
  int fail_count = 0, n_checks = 0, n, st, ab;
  // halt parks the request low; grant loss leaves it high as the controller requests the bus again
  bmx_row_t rows [7] = '{
    '{4'h4, 3'h4, 1'b0, 1'b0}, '{4'h4, 3'h1, 1'b0, 1'b0}, '{4'h2, 3'h4, 1'b0, 1'b1},
    '{4'h2, 3'h1, 1'b0, 1'b1}, '{4'h1, 3'h4, 1'b1, 1'b0}, '{4'h1, 3'h1, 1'b1, 1'b0},
    '{4'h8, 3'h4, 1'b1, 1'b0}};

  initial forever #2.5 ref_clk = ~ref_clk;

  bmx_bus_model u_bmx_bus_model (.ref_clk(ref_clk), .rst(rst), .grant_kill(exc[3]), .lat(lat),
    .bus_request_out(bus_request_out), .cyc_start(cyc_start), .cyc_abort(cyc_abort),
    .bus_grant_in(bus_grant_in), .cyc_ready(cyc_ready));
  bmx_ctrl u_bmx_ctrl (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reset_n_in(reset_n_in),
    .halt_n_in(~exc[2]), .bus_error_n_in(~exc[1]), .retry_n_in(~exc[0]), .bus_grant_in(bus_grant_in),
    .bus_request_out(bus_request_out), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
    .dma_pending(dma_pending), .dma_addr(dma_addr), .cyc_ready(cyc_ready), .cyc_last(1'b0),
    .cyc_start(cyc_start), .cyc_abort(cyc_abort), .cyc_addr(cyc_addr), .bus_error_in_pending(bus_error_in_pending),
    .bus_error_in_reported(bus_error_in_reported), .soft_reset(soft_reset));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bounded wait: 0 start, 1 request, 2 command ready
  task automatic wt(input int s, output int c);
    logic v;
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
      v = (s == 0) ? cyc_start : (s == 1) ? bus_request_out : cmd_ready;
    end while (v !== 1'b1 && c < 40);
    if (v !== 1'b1) begin
      chk(v, 1);
      wrap_up();
    end
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst = 0;
    chk(cmd_ready, 0);
    wt(2, n);
    exc = 4'h7; // exceptions while idle must be ignored
    repeat (5) @(posedge ref_clk);
    #1;
    chk(bus_request_out, 0);
    chk(bus_error_in_pending, 0);
    exc = 4'h0;
    dma_pending = 1;
    wt(1, n);
    chk(n <= 3, 1);
    $display("test idle done");
    foreach (rows[i]) begin
      a = 32'h0000_1000 + 32'(i);
      dma_addr = a;
      lat = rows[i].lat;
      wt(0, n);
      exc = rows[i].exc;
      dma_addr = ~a;
      st = 0;
      ab = 0;
      repeat (6) begin
        @(posedge ref_clk);
        #1;
        st += int'(cyc_start);
        ab |= int'(cyc_abort);
      end
      chk(32'(st), 0);
      chk(bus_request_out, rows[i].keep);
      chk(bus_error_in_pending, rows[i].bus_error_in);
      chk(32'(ab), 32'(rows[i].bus_error_in | rows[i].exc[0]));
      exc = 4'h0;
      wt(1, n);
      if (rows[i].exc[0]) begin
        wt(0, n);
        chk(cyc_addr, a);
      end
      if (rows[i].bus_error_in) begin
        bus_error_in_reported = 1;
        @(posedge ref_clk);
        #1 bus_error_in_reported = 0;
        @(posedge ref_clk);
        #1 chk(bus_error_in_pending, 0);
      end
      $display("test row %0d done", i);
    end
    wt(0, n);
    exc = 4'h2;
    repeat (3) @(posedge ref_clk);
    #1 exc = 4'h0;
    dma_pending = 0;
    wt(2, n);
    cmd_valid = 1;
    cmd_code = 8'hff;
    @(posedge ref_clk);
    #1 cmd_valid = 0;
    chk(soft_reset, 1);
    chk(cmd_ready, 0);
    wt(2, n);
    chk(n >= 4, 1);
    chk(bus_error_in_pending, 0);
    chk(bus_request_out, 0);
    $display("test soft reset done");
    dma_pending = 1;
    wt(0, n);
    reset_n_in = 0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk(bus_request_out, 0);
    chk(cmd_ready, 0);
    reset_n_in = 1;
    dma_pending = 0;
    wt(2, n);
    chk(n >= 4, 1);
    $display("test pin reset done");
    // clock enable low must freeze the idle sequencer despite pending work
    clk_en = 0;
    dma_pending = 1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(bus_request_out, 0);
    chk(cmd_ready, 1);
    clk_en = 1;
    wt(1, n);
    chk(n <= 3, 1);
    $display("test clock enable done");
    wrap_up();
  end
endmodule // bus_master_exception_control_tb
